// ### logic/fpas_pkg.sv
// Shared constants, types and state record for the floating add/subtract datapath
package fpas_pkg;

  // Datapath widths
  localparam int FRAC_W = 60;
  localparam int EXP_W  = 10;
  localparam int LZ_W   = 6;
  localparam int CODE_W = 4;

  // Fraction and exponent field positions
  localparam int FRAC_MSB   = 59;
  localparam int FRAC_HIDE  = 58;
  localparam int EXP_MSB    = 9;

  // Alignment limits, single and double precision
  localparam logic [EXP_W-1:0] OOR_SGL    = 10'h019;
  localparam logic [EXP_W-1:0] OOR_DBL    = 10'h039;
  localparam logic [EXP_W-1:0] ALIGN_STEP = 10'h008;
  localparam logic [EXP_W-1:0] EXP_ZERO   = 10'h000;
  localparam logic [3:0]       ALIGN_MAX  = 4'h8;

  // Normalization step and shift-control codes
  localparam logic [LZ_W-1:0]   NORM_STEP  = 6'h07;
  localparam logic [CODE_W-1:0] CODE_STEP  = 4'h7;
  localparam logic [CODE_W-1:0] CODE_RIGHT = 4'hF;
  localparam logic [CODE_W-1:0] CODE_NONE  = 4'h0;

  // Fraction constants, round bit at 34 (single) or 2 (double)
  localparam logic [FRAC_W-1:0] FRAC_ZERO    = 60'h000000000000000;
  localparam logic [FRAC_W-1:0] FRAC_ONE     = 60'h000000000000001;
  localparam logic [FRAC_W-1:0] FRAC_RND_SGL = 60'h000000400000000;
  localparam logic [FRAC_W-1:0] FRAC_RND_DBL = 60'h000000000000004;

  typedef logic [FRAC_W-1:0] fpas_frac_t;
  typedef logic [EXP_W-1:0]  fpas_exp_t;

  // One operand or result: sign, exponent, fraction
  typedef struct packed {
    logic       sign;
    fpas_exp_t  exp;
    fpas_frac_t frac;
  } fpas_opnd_s;

  // Floating condition codes
  typedef struct packed {
    logic n;
    logic z;
  } fpas_cc_s;

  typedef enum logic [3:0] {
    S_IDLE, S_LOOKUP, S_ALIGN, S_ARITH, S_ZTEST, S_ZRESTORE, S_NEGATE, S_NORM_ENC, S_NORM, S_DONE
  } fpas_state_e;

  // Whole state of the datapath sequencer
  typedef struct packed {
    fpas_state_e       state;
    fpas_frac_t        a;
    fpas_frac_t        q;
    fpas_exp_t         er;
    fpas_exp_t         sc;
    fpas_exp_t         dexp;
    fpas_exp_t         sexp;
    logic              sd;
    logic              ss;
    logic              op_sub;
    logic              dbl;
    logic              trunc;
    logic              diff_neg;
    logic              diff_zero;
    logic              rounded;
    logic              enc_right;
    logic              enc_within;
    logic [CODE_W-1:0] enc_code;
    logic              busy;
    logic              done;
    fpas_opnd_s        res;
    fpas_cc_s          cc;
  } fpas_core_s;

endpackage

// ### logic/fpas_align_rom.sv
// Exponent-difference lookup: magnitude, negative magnitude and out-of-range flag
`timescale 1ns/1ps
module fpas_align_rom
  import fpas_pkg::*;
(
  input  wire fpas_exp_t diff_i,
  input  wire logic      double_i,
  output fpas_exp_t      abs_o,
  output fpas_exp_t      neg_abs_o,
  output logic           oor_o
);

  // Difference is two's complement; bit 9 marks a negative difference
  always_comb begin
    abs_o     = diff_i[EXP_MSB] ? (EXP_ZERO - diff_i) : diff_i;
    neg_abs_o = EXP_ZERO - abs_o;
    oor_o     = abs_o > (double_i ? OOR_DBL : OOR_SGL);
  end

endmodule

// ### logic/fpas_norm_enc.sv
// Normalization shift encoder: direction, count and within-seven flag
`timescale 1ns/1ps
module fpas_norm_enc
  import fpas_pkg::*;
(
  input  wire fpas_frac_t   frac_i,
  output logic [CODE_W-1:0] code_o,
  output logic              right_o,
  output logic              within_o,
  output logic              zero_o
);

  logic [FRAC_MSB:0] seen_w;
  logic [LZ_W-1:0]   acc_w [0:FRAC_MSB];
  logic [LZ_W-1:0]   lz_w;

  assign seen_w[FRAC_MSB] = 1'b0;
  assign acc_w[FRAC_MSB]  = '0;

  // Priority chain from bit 58 down; the topmost one sets the left count
  genvar i;
  for (i = 0; i < FRAC_MSB; i++) begin : g_bit
    assign seen_w[i] = seen_w[i+1] | frac_i[i];
    assign acc_w[i]  = acc_w[i+1] | ((frac_i[i] & ~seen_w[i+1]) ? LZ_W'(FRAC_HIDE - i) : '0);
  end

  assign lz_w = acc_w[0];

  // Right shift wins; left counts above seven are clipped to one step
  always_comb begin
    right_o  = frac_i[FRAC_MSB];
    zero_o   = ~seen_w[0] & ~frac_i[FRAC_MSB];
    within_o = right_o | (lz_w <= NORM_STEP);
    if (right_o) begin
      code_o = CODE_RIGHT;
    end else if (within_o) begin
      code_o = lz_w[CODE_W-1:0];
    end else begin
      code_o = CODE_STEP;
    end
  end

endmodule

// ### logic/fpas_core.sv
// Floating add/subtract sequencer: sign, alignment, zero test, normalization, rounding
//
// Summary of operation
// - Subtract of negatives: keep dest sign if difference positive, else inverted source sign.
// - Alignment beyond 25 single or 57 double is skipped; larger operand returned unshifted.
// - Difference lookup yields negative magnitude and out-of-range flag; in range, load exponent.
// - Every nonzero result fraction leaves with bit 59 clear and bit 58 set; zero leaves as all zeros.
// - Unaligned subtract: negative nonzero; positive decremented, sign change means zero.
// - Normalization rounds or truncates by truncate select and updates condition codes.
// - Smaller-exponent fraction is right-shifted; result exponent is the larger one.
// - Step counter gets dest minus source exponent; dest fraction to A, source to Q.
// - Within eight, shift remaining count, then add or subtract, exponent gets larger one.
// - Beyond eight, shift smaller fraction eight and reduce step counter by eight, repeat.
// - Result sign from source if difference negative, from destination if positive.
// - Result bit 59 set shifts right one; bits 59 and 58 clear shift left.
// - Within seven, normalize in one pass; otherwise shift seven per pass and re-examine.
// - Shift count and direction are encoded one state before the shift happens.
// - Truncate passes shifted value; round adds bit 34 single or bit 2 double.
// - Rounding overflow into bit 59 is caught and corrected by a one-place shift.
// - Exponent adds right shifts and subtracts left shifts through the exponent mux.
// - One right shift sends four ones, sign-extended to ten, subtracted: exponent plus one.
// - Effective subtraction computes A minus B and checks for zero or negative.
// - Like-sign add or unlike-sign subtract is a magnitude addition.
// - A difference with bit 59 set is two's complemented before normalization.
// - A zero difference writes zeros to the destination accumulator.
`timescale 1ns/1ps
module fpas_core
  import fpas_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       start_i,
  input  wire logic       op_sub_i,
  input  wire logic       double_i,
  input  wire logic       truncate_select_i,
  input  wire fpas_opnd_s dest_i,
  input  wire fpas_opnd_s src_i,
  output logic            busy_o,
  output logic            done_o,
  output fpas_opnd_s      result_o,
  output fpas_cc_s        cc_o
);

  fpas_core_s        st_ff;
  fpas_core_s        nxt_st;

  fpas_exp_t         rom_abs;
  fpas_exp_t         rom_neg_abs;
  logic              rom_oor;
  logic [CODE_W-1:0] enc_code;
  logic              enc_right;
  logic              enc_within;
  logic              enc_zero;

  logic              eff_sub;
  logic              neg_sign;
  fpas_exp_t         big_exp;
  logic [3:0]        align_amt;
  fpas_frac_t        small_sh;
  fpas_frac_t        fsum;
  fpas_frac_t        fdiff;
  fpas_frac_t        fdec;
  fpas_frac_t        finc;
  fpas_frac_t        fneg;
  fpas_frac_t        norm_sh;
  fpas_frac_t        rbit;
  fpas_exp_t         bmx_val;
  fpas_exp_t         er_adj;
  logic              do_round;

  // Difference lookup on the step counter
  fpas_align_rom u_rom (
    .diff_i    (st_ff.sc),
    .double_i  (st_ff.dbl),
    .abs_o     (rom_abs),
    .neg_abs_o (rom_neg_abs),
    .oor_o     (rom_oor)
  );

  // Encoder watches the A fraction as it returns from the ALU
  fpas_norm_enc u_enc (
    .frac_i   (st_ff.a),
    .code_o   (enc_code),
    .right_o  (enc_right),
    .within_o (enc_within),
    .zero_o   (enc_zero)
  );

  // Effective operation and signs
  assign eff_sub  = st_ff.op_sub ? (st_ff.ss == st_ff.sd) : (st_ff.ss != st_ff.sd);
  assign neg_sign = st_ff.op_sub ? ~st_ff.ss : st_ff.ss;
  assign big_exp  = st_ff.diff_neg ? st_ff.sexp : st_ff.dexp;

  // Alignment shifter: at most eight places per state
  assign align_amt = (st_ff.sc > ALIGN_STEP) ? ALIGN_MAX : st_ff.sc[3:0];
  assign small_sh  = (st_ff.diff_neg ? st_ff.a : st_ff.q) >> align_amt;

  // Fraction ALU, 60 bits, no carry out kept
  assign fsum  = st_ff.a + st_ff.q;
  assign fdiff = st_ff.a - st_ff.q;
  assign fdec  = st_ff.a - FRAC_ONE;
  assign finc  = st_ff.a + FRAC_ONE;
  assign fneg  = FRAC_ZERO - st_ff.a;

  // Normalizing shifter uses the code registered one state earlier
  assign norm_sh  = st_ff.enc_right ? {1'b0, st_ff.a[FRAC_MSB:1]} : (st_ff.a << st_ff.enc_code);
  assign rbit     = st_ff.dbl ? FRAC_RND_DBL : FRAC_RND_SGL;
  assign do_round = st_ff.enc_within & ~st_ff.rounded & ~st_ff.trunc;

  // Exponent mux sign-extends the four-bit code; the ALU subtracts it
  assign bmx_val = {{(EXP_W-CODE_W){st_ff.enc_code[CODE_W-1]}}, st_ff.enc_code};
  assign er_adj  = st_ff.er - bmx_val;

  // Sequencer: one microstate per state, all state in one record
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    unique case (st_ff.state)
      S_IDLE: begin
        if (start_i) begin
          nxt_st.sc      = dest_i.exp - src_i.exp;
          nxt_st.a       = dest_i.frac;
          nxt_st.q       = src_i.frac;
          nxt_st.sd      = dest_i.sign;
          nxt_st.ss      = src_i.sign;
          nxt_st.dexp    = dest_i.exp;
          nxt_st.sexp    = src_i.exp;
          nxt_st.op_sub  = op_sub_i;
          nxt_st.dbl     = double_i;
          nxt_st.trunc   = truncate_select_i;
          nxt_st.rounded = 1'b0;
          nxt_st.state   = S_LOOKUP;
        end
      end
      S_LOOKUP: begin
        nxt_st.diff_neg  = st_ff.sc[EXP_MSB];
        nxt_st.diff_zero = (st_ff.sc == EXP_ZERO);
        if (rom_oor) begin
          // Smaller operand would fall off the register: larger one is the answer
          nxt_st.a     = st_ff.sc[EXP_MSB] ? st_ff.q : st_ff.a;
          nxt_st.er    = st_ff.sc[EXP_MSB] ? st_ff.sexp : st_ff.dexp;
          nxt_st.sd    = (st_ff.sc[EXP_MSB] && eff_sub) ? neg_sign : st_ff.sd;
          nxt_st.state = S_DONE;
        end else begin
          nxt_st.er    = rom_neg_abs;
          nxt_st.sc    = rom_abs;
          nxt_st.state = S_ALIGN;
        end
      end
      S_ALIGN: begin
        if (st_ff.diff_neg) begin
          nxt_st.a = small_sh;
        end else begin
          nxt_st.q = small_sh;
        end
        if (st_ff.sc > ALIGN_STEP) begin
          nxt_st.sc = st_ff.sc - ALIGN_STEP;
          nxt_st.er = st_ff.er + ALIGN_STEP;
        end else begin
          nxt_st.sc    = EXP_ZERO;
          nxt_st.er    = big_exp;
          nxt_st.state = S_ARITH;
        end
      end
      S_ARITH: begin
        if (!eff_sub) begin
          nxt_st.a     = fsum;
          nxt_st.state = S_NORM_ENC;
        end else begin
          nxt_st.a = fdiff;
          if (st_ff.diff_zero) begin
            nxt_st.state = S_ZTEST;
          end else if (st_ff.diff_neg) begin
            nxt_st.state = S_NEGATE;
          end else begin
            // Aligned source is smaller: difference cannot be negative or zero
            nxt_st.state = S_NORM_ENC;
          end
        end
      end
      S_ZTEST: begin
        if (st_ff.a[FRAC_MSB]) begin
          nxt_st.state = S_NEGATE;
        end else begin
          nxt_st.a = fdec;
          if (fdec[FRAC_MSB]) begin
            nxt_st.a     = FRAC_ZERO;
            nxt_st.er    = EXP_ZERO;
            nxt_st.sd    = 1'b0;
            nxt_st.state = S_DONE;
          end else begin
            nxt_st.state = S_ZRESTORE;
          end
        end
      end
      S_ZRESTORE: begin
        // Undo the probe decrement before normalizing
        nxt_st.a     = finc;
        nxt_st.state = S_NORM_ENC;
      end
      S_NEGATE: begin
        nxt_st.a     = fneg;
        nxt_st.sd    = neg_sign;
        nxt_st.state = S_NORM_ENC;
      end
      S_NORM_ENC: begin
        nxt_st.enc_right  = enc_right;
        nxt_st.enc_within = enc_within;
        nxt_st.enc_code   = enc_code;
        if (enc_zero) begin
          // Zero sum would never normalize; deliver a clean zero
          nxt_st.a     = FRAC_ZERO;
          nxt_st.er    = EXP_ZERO;
          nxt_st.sd    = 1'b0;
          nxt_st.state = S_DONE;
        end else if (!enc_right && (enc_code == CODE_NONE) && st_ff.rounded) begin
          nxt_st.state = S_DONE;
        end else begin
          nxt_st.state = S_NORM;
        end
      end
      S_NORM: begin
        // Round overflow lands in bit 59 and is caught on the next encode
        nxt_st.a  = do_round ? (norm_sh + rbit) : norm_sh;
        nxt_st.er = er_adj;
        if (st_ff.enc_within) begin
          nxt_st.rounded = 1'b1;
        end
        nxt_st.state = S_NORM_ENC;
      end
      S_DONE: begin
        nxt_st.res.sign = st_ff.sd;
        nxt_st.res.exp  = st_ff.er;
        nxt_st.res.frac = st_ff.a;
        nxt_st.cc.n     = st_ff.sd;
        nxt_st.cc.z     = (st_ff.a == FRAC_ZERO);
        nxt_st.done     = 1'b1;
        nxt_st.state    = S_IDLE;
      end
      default: begin
        nxt_st.state = S_IDLE;
      end
    endcase
    nxt_st.busy = (nxt_st.state != S_IDLE);
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come straight from the state record
  assign busy_o   = st_ff.busy;
  assign done_o   = st_ff.done;
  assign result_o = st_ff.res;
  assign cc_o     = st_ff.cc;

  // Nonzero results leave normalized
  a_result_norm: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    done_o && !cc_o.z |-> !result_o.frac[FRAC_MSB] && result_o.frac[FRAC_HIDE])
    else $error("result fraction not normalized");

  // Out-of-range difference skips alignment and finishes next
  a_oor_skip: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (st_ff.state == S_LOOKUP) && rom_oor |=> (st_ff.state == S_DONE)
      && (st_ff.a == ($past(st_ff.sc[EXP_MSB]) ? $past(st_ff.q) : $past(st_ff.a))) ##1 done_o)
    else $error("out of range difference did not return larger operand");

  // In range, exponent register holds the negative magnitude
  a_lookup_er: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (st_ff.state == S_LOOKUP) && !rom_oor |=> (st_ff.er == $past(rom_neg_abs)) && (st_ff.state == S_ALIGN))
    else $error("negative difference not loaded");

  // Start loads step counter and fractions
  a_start_load: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (st_ff.state == S_IDLE) && start_i |=> (st_ff.sc == $past(dest_i.exp) - $past(src_i.exp))
      && (st_ff.a == $past(dest_i.frac)) && (st_ff.q == $past(src_i.frac)))
    else $error("operands not loaded on start");

  // Long alignment steps by eight
  a_align_step: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (st_ff.state == S_ALIGN) && (st_ff.sc > ALIGN_STEP) |=> (st_ff.sc == $past(st_ff.sc) - ALIGN_STEP)
      && (st_ff.state == S_ALIGN))
    else $error("alignment step not eight");

  // Last alignment pass loads the larger exponent
  a_align_end: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (st_ff.state == S_ALIGN) && (st_ff.sc <= ALIGN_STEP) |=> (st_ff.state == S_ARITH)
      && (st_ff.er == ($past(st_ff.diff_neg) ? st_ff.sexp : st_ff.dexp)))
    else $error("larger exponent not loaded after alignment");

  // A single right normalization raises the exponent by one
  // A round carry may set bit 59 again; the next encode corrects it
  a_right_incr: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (st_ff.state == S_NORM) && st_ff.enc_right |=> (st_ff.er == $past(st_ff.er) + 10'h001)
      && (!st_ff.a[FRAC_MSB] || $past(do_round)))
    else $error("right normalization did not increment exponent");

  // Encoded code is applied in the state after encoding
  a_enc_ahead: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (st_ff.state == S_NORM_ENC) && !enc_zero ##1 (st_ff.state == S_NORM)
      |-> (st_ff.enc_code == $past(enc_code)) && (st_ff.enc_right == st_ff.a[FRAC_MSB])
      && (st_ff.enc_right || !st_ff.enc_within || norm_sh[FRAC_HIDE]))
    else $error("shift code not registered ahead of shift");

  // Negative unaligned difference is never mistaken for zero
  a_ztest_neg: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (st_ff.state == S_ZTEST) && st_ff.a[FRAC_MSB] |=> (st_ff.state == S_NEGATE))
    else $error("negative difference taken for zero");

  // A zero difference is written as zeros and finishes
  a_zero_write: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (st_ff.state == S_ZTEST) && !st_ff.a[FRAC_MSB] && (st_ff.a == FRAC_ZERO)
      |=> (st_ff.a == FRAC_ZERO) ##1 done_o && cc_o.z && !result_o.sign)
    else $error("zero difference not reported as zero");

  // Negative difference is complemented and signed from the source
  a_neg_comp: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (st_ff.state == S_NEGATE) |=> (st_ff.a == FRAC_ZERO - $past(st_ff.a))
      && (st_ff.sd == ($past(st_ff.op_sub) ? ~$past(st_ff.ss) : $past(st_ff.ss))))
    else $error("negative difference not complemented");

  // Truncate mode passes the shifted fraction untouched
  a_trunc_pass: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (st_ff.state == S_NORM) && st_ff.trunc |=> st_ff.a == $past(norm_sh))
    else $error("truncate mode altered the fraction");

endmodule

// ### sim/fpas_host.sv
// Host model: issues operand pairs to the add/subtract datapath and collects results
`timescale 1ns/1ps
module fpas_host
  import fpas_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       busy_i,
  input  wire logic       done_i,
  input  wire fpas_opnd_s result_i,
  input  wire fpas_cc_s   cc_i,
  output logic            start_o,
  output logic            op_sub_o,
  output logic            double_o,
  output logic            truncate_select_o,
  output fpas_opnd_s      dest_o,
  output fpas_opnd_s      src_o
);
  // Quiet lines at time zero
  initial begin
    {start_o, op_sub_o, double_o, truncate_select_o} = 4'h0;
    dest_o = '0;
    src_o = '0;
  end

  // Request held to the taking edge, then lines scrambled so late sampling shows
  task automatic fire(input fpas_opnd_s d, input fpas_opnd_s s, input logic [2:0] mode);
    {op_sub_o, double_o, truncate_select_o} = mode;
    dest_o = d;
    src_o = s;
    start_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    {op_sub_o, double_o, truncate_select_o} = ~mode;
    dest_o = ~d;
    src_o = ~s;
  endtask

  // One operation; poke raises a stray start while the engine works
  task automatic issue(input fpas_opnd_s d, input fpas_opnd_s s, input logic [2:0] mode, input logic poke,
                       output fpas_opnd_s r, output fpas_cc_s c, output int cyc);
    fire(d, s, mode);
    // Count edges from the taking edge up to the edge that samples done
    cyc = 1;
    while (done_i !== 1'b1 && cyc < 100) begin
      start_o = poke && cyc == 1 && busy_i;
      @(posedge ref_clk_i);
      #1;
      cyc++;
    end
    r = result_i;
    c = cc_i;
  endtask
endmodule

// ### sim/tb.sv
// Self-checking bench for the floating add/subtract datapath
`timescale 1ns/1ps
module tb
  import fpas_pkg::*;
();
  logic       ref_clk_i;
  logic       rstn_i;
  logic       start, op_sub, dbl, trunc, busy, done;
  fpas_opnd_s dest, src, res, d, s, r;
  fpas_cc_s   cc, c;
  int         n_errors, check_count, seed, cyc;
  logic [9:0] span [4] = '{10'h019, 10'h01A, 10'h039, 10'h03A};
  localparam fpas_opnd_s W = {1'b0, 10'h081, 60'h400000000000000};

  fpas_core u_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .start_i(start), .op_sub_i(op_sub),
    .double_i(dbl), .truncate_select_i(trunc), .dest_i(dest), .src_i(src), .busy_o(busy),
    .done_o(done), .result_o(res), .cc_o(cc));
  fpas_host u_host (.ref_clk_i(ref_clk_i), .busy_i(busy), .done_i(done), .result_i(res), .cc_i(cc),
    .start_o(start), .op_sub_o(op_sub), .double_o(dbl), .truncate_select_o(trunc), .dest_o(dest),
    .src_o(src));

  // 250 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Expected result; mode is {subtract, double, truncate}
  function automatic fpas_opnd_s ref_op(input fpas_opnd_s a, input fpas_opnd_s b, input logic [2:0] m);
    fpas_opnd_s o;
    fpas_exp_t  df;
    fpas_exp_t  ad;
    logic       eadd;
    logic       sbig;
    fpas_frac_t f;
    df = a.exp - b.exp;
    ad = df[EXP_MSB] ? EXP_ZERO - df : df;
    eadd = m[2] ^ (a.sign == b.sign);
    sbig = df[EXP_MSB] || (df == EXP_ZERO && b.frac > a.frac);
    o.sign = (eadd || !sbig) ? a.sign : m[2] ^ b.sign;
    o.exp = df[EXP_MSB] ? b.exp : a.exp;
    o.frac = sbig ? b.frac : a.frac;
    if (ad > (m[1] ? OOR_DBL : OOR_SGL)) return o;
    f = sbig ? a.frac >> ad : b.frac >> ad;
    f = eadd ? o.frac + f : o.frac - f;
    if (f == FRAC_ZERO) return '0;
    o.exp = o.exp + EXP_W'(f[FRAC_MSB]);
    f = f >> f[FRAC_MSB];
    while (!f[FRAC_HIDE]) begin
      f = f << 1;
      o.exp = o.exp - 10'h001;
    end
    // Round once, then undo a carry into bit 59
    if (!m[0]) f = f + (m[1] ? FRAC_RND_DBL : FRAC_RND_SGL);
    o.exp = o.exp + EXP_W'(f[FRAC_MSB]);
    o.frac = f >> f[FRAC_MSB];
    return o;
  endfunction

  // Normalized random operand
  function automatic fpas_opnd_s opnd(input fpas_exp_t e);
    return {1'($random(seed)), e, 2'b01, 26'($random(seed)), 32'($random(seed))};
  endfunction

  task automatic run(input fpas_opnd_s a, input fpas_opnd_s b, input logic [2:0] m, input logic p, input int lat);
    fpas_opnd_s e;
    fpas_opnd_s g;
    fpas_cc_s   k;
    int         n;
    e = ref_op(a, b, m);
    u_host.issue(a, b, m, p, g, k, n);
    chk("busy at done", 2'b01, {busy, done});
    chk("result", e, g);
    chk("cc", {e.sign, e.frac == FRAC_ZERO}, k);
    if (lat > 0) chk("latency", lat, n);
    chk("bounded", 1, n <= 45);
  endtask

  task automatic end_sim();
    $display("Counts: %0d checks, %0d mismatches", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog well past the expected run length
  initial begin
    #300000;
    n_errors++;
    $display("BAD watchdog expired");
    end_sim();
  end

  // Main sequence
  initial begin
    n_errors = 0;
    check_count = 0;
    seed = 32'h51fd;
    rstn_i = 1'b0;
    repeat (12) @(posedge ref_clk_i);
    #1;
    rstn_i = 1'b1;
    chk("reset outputs", 0, {busy, done, res, cc});
    run(W, W, 3'h1, 1'b0, 8);
    run(W, W, 3'h5, 1'b0, 0);
    run({1'b1, 10'h083, 60'h500000000000000}, {1'b1, 10'h082, 60'h600000000000000}, 3'h5, 1'b0, 0);
    run({1'b1, 10'h082, 60'h600000000000000}, {1'b1, 10'h083, 60'h500000000000000}, 3'h5, 1'b0, 0);
    $display("test signs done");
    // Limits 25 and 57 against one beyond, both directions
    for (int i = 0; i < 4; i++) begin
      run(opnd(10'h100 + span[i]), opnd(10'h100), {1'b0, i > 1, 1'b1}, 1'b0, i % 2 ? 3 : 0);
      run(opnd(10'h100), opnd(10'h100 + span[i]), {1'b1, i > 1, 1'b0}, 1'b0, 0);
    end
    $display("test range done");
    run({1'b0, 10'h200, 60'h400000000000001}, {1'b0, 10'h200, 60'h400000000000000}, 3'h5, 1'b0, 0);
    run({1'b0, 10'h200, 60'h400000000000003}, {1'b0, 10'h200, 60'h400000000000000}, 3'h4, 1'b0, 0);
    run({1'b0, 10'h150, 60'h7FFFFFFFFFFFFFF}, {1'b0, 10'h117, 60'h400000000000000}, 3'h6, 1'b0, 0);
    run(opnd(10'h180), opnd(10'h17C), 3'h0, 1'b1, 0);
    $display("test normalize done");
    // Random operands over all modes, every tenth a self pair
    for (int i = 0; i < 400; i++) begin
      d = opnd(10'h100 + 10'(6'($random(seed))));
      s = (i % 10 == 0) ? d : opnd(10'h100 + 10'(6'($random(seed))));
      run(d, s, 3'($random(seed)), 1'b0, 0);
    end
    $display("test random done");
    // Reset in the done cycle of an out-of-range add clears everything
    fork
      u_host.issue(opnd(10'h120), opnd(10'h100), 3'h0, 1'b0, r, c, cyc);
      begin
        repeat (3) @(posedge ref_clk_i);
        #1;
        rstn_i = 1'b0;
        #1;
        chk("mid reset", 0, {busy, done, res, cc});
        repeat (2) @(posedge ref_clk_i);
        #1;
        rstn_i = 1'b1;
      end
    join
    run(W, W, 3'h1, 1'b0, 8);
    $display("test reset done");
    end_sim();
  end
endmodule
